// ### core/sit_regs.vh
// Register offsets, protocol codes and field positions of the sensor target control
`ifndef SIT_REGS_VH
`define SIT_REGS_VH
`define SIT_ADDR_BCAST 7'h7e
`define SIT_ADDR_STATIC 7'h30
`define SIT_ADDR_P2P 7'h01
`define SIT_CCC_ENTDAA 8'h07
`define SIT_CCC_SETXTIME_B 8'h28
`define SIT_CCC_SETDASA 8'h87
`define SIT_CCC_GETSTATUS 8'h90
`define SIT_CCC_GETHDRCAP 8'h95
`define SIT_CCC_SETXTIME_D 8'h98
`define SIT_CCC_NONE 8'h00
`define SIT_XT_ST 8'h7f
`define SIT_XT_DT 8'hbf
`define SIT_XT_TPH 8'h3f
`define SIT_XT_TU 8'h9f
`define SIT_XT_ODR 8'h8f
`define SIT_HDRCAP_VAL 8'h01
`define SIT_REG_FIFO 8'h0e
`define SIT_REG_STAT1 8'h18
`define SIT_REG_STAT0 8'h19
`define SIT_REG_CTRL 8'h1b
`define SIT_REG_THR_X 8'h1e
`define SIT_REG_THR_Y 8'h1f
`define SIT_REG_THR_Z 8'h20
`define SIT_REG_PASSWD 8'h21
`define SIT_REG_STV_X 8'h27
`define SIT_REG_STV_Y 8'h28
`define SIT_REG_STV_Z 8'h29
`define SIT_REG_ODR 8'h2a
`define SIT_REG_TPH 8'h2b
`define SIT_REG_TU 8'h2c
`define SIT_CTRL_SELFTEST 8'h41
`define SIT_PASSWD_CODE 8'he1
`define SIT_FIFO_EN_BIT 0
`define SIT_FIFO_LOOP_BIT 7
`define SIT_STAT1_SAT_MASK 8'h20
`define SIT_DAA_BITS 7'd64
`define SIT_DAA_LAST 7'd71
`define SIT_DAA_ACK 7'd72
`define SIT_DAA_HDR 7'h7f
`define SIT_BYTE_LAST 4'd7
`define SIT_ACK_SLOT 4'd8
`endif

// ### core/sit_target.v
// Sensor host-interface target: I2C/I3C SDR engine, address assignment, CCCs and registers
// Notes on behaviour
// (RQ1) Starts in I2C; any access to 0x7E switches to I3C until power-off.
// (RQ2) Static address 0x30 answers I2C and serves direct dynamic assignment.
// (RQ3) Controller should assign the dynamic address with SETDASA to the static address.
// (RQ4) Point-to-point bus is a SETDASA special case, also accepted on address 0x01.
// (RQ5) Joins ENTDAA, sending a fixed 48-bit provisional id with arbitration.
// (RQ6) With a dynamic address, SDR register reads, writes and supported CCCs work.
// (RQ7) Two-byte status returns primary status 0x18 then secondary status 0x19.
// (RQ8) GETHDRCAP answers 0x01, only DDR mode supported.
// (RQ9) Pending interrupt raises an IBI; its mandatory byte is primary status.
// (RQ10) SETXTIME 0x7F latches that transfer's START as sync reference.
// (RQ11) SETXTIME 0xBF captures one byte as delay time.
// (RQ12) SETXTIME 0x3F captures one byte as sync period.
// (RQ13) SETXTIME 0x9F captures one byte as time unit.
// (RQ14) SETXTIME 0x8F captures one byte as output data rate.
// (RQ15) ODR, period, unit by register or SETXTIME; tick and delay only SETXTIME.
// (RQ16) Host writes 80 percent of stored self-test values as thresholds.
// (RQ17) Writing 0x41 to control register 0x1B starts a self-test.
// (RQ18) Self-test result shows in the saturation bit of status 0x18; zero passes.
// (RQ19) Host applies password by writing 0xE1 to register 0x21.
// (RQ20) Host enables FIFO alone by writing 0x01 to register 0x0E.
// (RQ21) Host enables FIFO with loopback by writing 0x81 to register 0x0E.
// (RQ22) Host removes offset by SET, measure, RESET, measure, halving difference.
`timescale 1ns/1ps
`include "sit_regs.vh"
module sit_target #(
  parameter [47:0] PID = 48'h0a0b_0c0d_0e0f, // Arbitrary provisional id
  parameter [7:0] BCR = 8'h26,
  parameter [7:0] DCR = 8'h00,
  parameter [6:0] STATIC_ADDR = `SIT_ADDR_STATIC,
  parameter TS_W = 16
)
(
  input wire sys_clk,
  input wire rst,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire ibi_pending,
  input wire sat_sensor,
  input wire [7:0] status_flags,
  input wire [7:0] secondary_status,
  input wire [23:0] selftest_value,
  output reg i3c_mode,
  output reg [6:0] dyn_addr,
  output reg dyn_addr_valid,
  output reg ctrl_wr,
  output reg [7:0] ctrl_data,
  output reg selftest_start,
  output reg password_wr,
  output reg fifo_en,
  output reg fifo_loopback,
  output reg [23:0] selftest_threshold,
  output reg [7:0] odr,
  output reg [7:0] sync_period,
  output reg [7:0] time_unit,
  output reg [7:0] delay_time,
  output reg sync_tick,
  output reg [TS_W-1:0] sync_ref,
  output reg ibi_done
);
  // ****************************************************
  // Pin sampling and bus conditions
  // ****************************************************
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_WR = 3'd2;
  localparam ST_RD = 3'd3;
  localparam ST_DAA = 3'd4;
  localparam ST_IGN = 3'd5;
  reg scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end
    else
    begin
      scl_s1_q <= scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end
  wire scl_rise = scl_s2_q & ~scl_s3_q;
  wire scl_fall = ~scl_s2_q & scl_s3_q;
  wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire stop_det = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  // ****************************************************
  // Transfer state
  // ****************************************************
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q, tx_q, ccc_q, ptr_q, def_q;
  reg [6:0] daa_cnt_q;
  reg [1:0] wr_idx_q;
  reg [TS_W-1:0] ts_q, start_ts_q;
  reg ack_q, bcast_q, ibi_arm_q, ibi_q, daa_arm_q;
  wire [7:0] rx_byte = {sh_q[6:0], sda_s2_q};
  wire [6:0] rx_addr = rx_byte[7:1];
  wire [63:0] daa_word = {PID, BCR, DCR};
  wire daa_bit = daa_word[6'd63 - daa_cnt_q[5:0]];
  wire [7:0] ibi_hdr = {dyn_addr, 1'b1};
  wire [1:0] xi = bcast_q ? wr_idx_q - 2'd1 : wr_idx_q;
  wire [6:0] own_addr = (i3c_mode & dyn_addr_valid) ? dyn_addr : STATIC_ADDR;
  wire dasa_ctx = (ccc_q == `SIT_CCC_SETDASA);
  // (RQ18) Saturation bit
  wire [7:0] primary_status = (status_flags & ~`SIT_STAT1_SAT_MASK) |
                       (sat_sensor ? `SIT_STAT1_SAT_MASK : 8'h00);
  // (RQ9) IBI header match
  wire ibi_hit = ibi_arm_q & (rx_byte == ibi_hdr);
  wire plain_rd = (ccc_q != `SIT_CCC_GETSTATUS) & (ccc_q != `SIT_CCC_GETHDRCAP);
  // ****************************************************
  // Read data selection
  // ****************************************************
  // Plain process so every register read is in the sensitivity list
  reg [7:0] rd_val;
  always @*
  begin
    if (ptr_q == `SIT_REG_STAT1)
      rd_val = primary_status;
    else if (ptr_q == `SIT_REG_STAT0)
      rd_val = secondary_status;
    else if (ptr_q == `SIT_REG_FIFO)
      rd_val = {fifo_loopback, 6'h00, fifo_en};
    else if (ptr_q == `SIT_REG_THR_X)
      rd_val = selftest_threshold[7:0];
    else if (ptr_q == `SIT_REG_THR_Y)
      rd_val = selftest_threshold[15:8];
    else if (ptr_q == `SIT_REG_THR_Z)
      rd_val = selftest_threshold[23:16];
    else if (ptr_q == `SIT_REG_STV_X)
      rd_val = selftest_value[7:0];
    else if (ptr_q == `SIT_REG_STV_Y)
      rd_val = selftest_value[15:8];
    else if (ptr_q == `SIT_REG_STV_Z)
      rd_val = selftest_value[23:16];
    else if (ptr_q == `SIT_REG_ODR)
      rd_val = odr;
    else if (ptr_q == `SIT_REG_TPH)
      rd_val = sync_period;
    else if (ptr_q == `SIT_REG_TU)
      rd_val = time_unit;
    else
      rd_val = 8'h00;
  end
  reg [7:0] tx_next;
  always @*
  begin
    // (RQ7) Status word order
    if (ccc_q == `SIT_CCC_GETSTATUS)
      tx_next = (state_q == ST_ADDR) ? primary_status : secondary_status;
    // (RQ8) HDR capability
    else if (ccc_q == `SIT_CCC_GETHDRCAP)
      tx_next = `SIT_HDRCAP_VAL;
    else
      tx_next = rd_val;
  end
  // ****************************************************
  // Protocol engine
  // ****************************************************
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'd0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ccc_q <= `SIT_CCC_NONE;
      ptr_q <= 8'h00;
      def_q <= 8'h00;
      daa_cnt_q <= 7'd0;
      wr_idx_q <= 2'd0;
      ts_q <= {TS_W{1'b0}};
      start_ts_q <= {TS_W{1'b0}};
      ack_q <= 1'b0;
      bcast_q <= 1'b0;
      ibi_arm_q <= 1'b0;
      ibi_q <= 1'b0;
      daa_arm_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      i3c_mode <= 1'b0;
      dyn_addr <= 7'h00;
      dyn_addr_valid <= 1'b0;
      ctrl_wr <= 1'b0;
      ctrl_data <= 8'h00;
      selftest_start <= 1'b0;
      password_wr <= 1'b0;
      fifo_en <= 1'b0;
      fifo_loopback <= 1'b0;
      selftest_threshold <= 24'h000000;
      odr <= 8'h00;
      sync_period <= 8'h00;
      time_unit <= 8'h00;
      delay_time <= 8'h00;
      sync_tick <= 1'b0;
      sync_ref <= {TS_W{1'b0}};
      ibi_done <= 1'b0;
    end
    else
    begin
      ctrl_wr <= 1'b0;
      selftest_start <= 1'b0;
      password_wr <= 1'b0;
      sync_tick <= 1'b0;
      ibi_done <= 1'b0;
      ts_q <= ts_q + 1'b1;
      if (start_det)
      begin
        // Our own IBI pull stays on across its START
        start_ts_q <= ts_q;
        ibi_arm_q <= (state_q == ST_IDLE) & sda_oe;
        state_q <= ST_ADDR;
        cnt_q <= 4'd0;
        wr_idx_q <= 2'd0;
        ack_q <= 1'b0;
        ibi_q <= 1'b0;
      end
      else if (stop_det)
      begin
        state_q <= ST_IDLE;
        ccc_q <= `SIT_CCC_NONE;
        daa_arm_q <= 1'b0;
        sda_oe <= 1'b0;
      end
      else if (state_q == ST_IDLE)
      begin
        // (RQ9) Request IBI while pending
        sda_oe <= ibi_pending & i3c_mode & dyn_addr_valid & scl_s2_q;
        sda_out <= 1'b0;
      end
      else if (state_q == ST_DAA)
      begin
        if (scl_rise)
        begin
          daa_cnt_q <= daa_cnt_q + 1'b1;
          sh_q <= rx_byte;
          // (RQ5) Lost arbitration drops out
          if (daa_cnt_q < `SIT_DAA_BITS && daa_bit && !sda_s2_q)
          begin
            state_q <= ST_IGN;
            sda_oe <= 1'b0;
          end
          // Only a well-formed address gets its ack
          ack_q <= (daa_cnt_q == `SIT_DAA_LAST) & ^rx_byte;
          if (daa_cnt_q == `SIT_DAA_LAST && ^rx_byte)
          begin
            dyn_addr <= rx_addr;
            dyn_addr_valid <= 1'b1;
          end
        end
        else if (scl_fall)
        begin
          sda_out <= 1'b0;
          if (daa_cnt_q == `SIT_DAA_HDR)
            sda_oe <= 1'b1;
          else if (daa_cnt_q < `SIT_DAA_BITS)
            sda_oe <= ~daa_bit;
          else
          begin
            // Ack stands until the fall that ends its slot
            sda_oe <= (daa_cnt_q == `SIT_DAA_ACK) & ack_q;
            if (daa_cnt_q > `SIT_DAA_ACK)
              state_q <= ST_IGN;
          end
        end
      end
      else if (scl_rise && state_q != ST_IGN)
      begin
        if (cnt_q != `SIT_ACK_SLOT)
        begin
          sh_q <= rx_byte;
          cnt_q <= cnt_q + 1'b1;
        end
        else
        begin
          cnt_q <= 4'd0;
          ack_q <= 1'b0;
          // Our own address ack is no controller ack; keep the loaded byte
          if (state_q == ST_RD && !ack_q)
          begin
            if (!sda_s2_q && !ibi_q)
            begin
              tx_q <= tx_next;
              if (plain_rd)
                ptr_q <= ptr_q + 1'b1;
            end
            else
            begin
              state_q <= ST_IGN;
              ibi_done <= ibi_q;
            end
          end
        end
        if (cnt_q == `SIT_BYTE_LAST && state_q == ST_ADDR)
        begin
          if (rx_addr == `SIT_ADDR_BCAST)
          begin
            // (RQ1) One-way switch to I3C
            i3c_mode <= 1'b1;
            bcast_q <= ~rx_byte[0];
            ack_q <= ~rx_byte[0] | (daa_arm_q & ~dyn_addr_valid);
            if (!rx_byte[0])
              state_q <= ST_WR;
            else if (daa_arm_q && !dyn_addr_valid)
            begin
              state_q <= ST_DAA;
              daa_cnt_q <= `SIT_DAA_HDR;
            end
            else
              state_q <= ST_IGN;
          end
          else if (ibi_hit)
          begin
            ibi_q <= 1'b1;
            ack_q <= 1'b1;
            state_q <= ST_RD;
            tx_q <= primary_status;
          end
          // (RQ2) Static address match
          // (RQ4) Point-to-point assignment
          else if (rx_addr == own_addr ||
                   (dasa_ctx && (rx_addr == STATIC_ADDR || rx_addr == `SIT_ADDR_P2P)))
          begin
            ack_q <= 1'b1;
            bcast_q <= 1'b0;
            state_q <= rx_byte[0] ? ST_RD : ST_WR;
            tx_q <= tx_next;
            if (rx_byte[0] && plain_rd)
              ptr_q <= ptr_q + 1'b1;
          end
          else
            state_q <= ST_IGN;
        end
        else if (cnt_q == `SIT_BYTE_LAST && state_q == ST_WR)
        begin
          ack_q <= 1'b1;
          if (wr_idx_q != 2'd3)
            wr_idx_q <= wr_idx_q + 1'b1;
          if (bcast_q && wr_idx_q == 2'd0)
          begin
            ccc_q <= rx_byte;
            if (rx_byte == `SIT_CCC_ENTDAA)
              daa_arm_q <= 1'b1;
          end
          else if (bcast_q && ccc_q != `SIT_CCC_SETXTIME_B)
            ack_q <= 1'b1;
          // (RQ3) Address taken from SETDASA
          else if (dasa_ctx)
          begin
            if (wr_idx_q == 2'd0)
            begin
              dyn_addr <= rx_addr;
              dyn_addr_valid <= 1'b1;
            end
          end
          else if (bcast_q || ccc_q == `SIT_CCC_SETXTIME_D)
          begin
            if (xi == 2'd0)
            begin
              def_q <= rx_byte;
              // (RQ10) Sync tick reference
              if (rx_byte == `SIT_XT_ST)
              begin
                sync_tick <= 1'b1;
                sync_ref <= start_ts_q;
              end
            end
            else if (xi == 2'd1)
            begin
              // (RQ11) Delay time
              if (def_q == `SIT_XT_DT)
                delay_time <= rx_byte;
              // (RQ12) Sync period
              if (def_q == `SIT_XT_TPH)
                sync_period <= rx_byte;
              // (RQ13) Time unit
              if (def_q == `SIT_XT_TU)
                time_unit <= rx_byte;
              // (RQ14) Output data rate
              if (def_q == `SIT_XT_ODR)
                odr <= rx_byte;
            end
          end
          // (RQ6) SDR register access
          else if (wr_idx_q == 2'd0)
            ptr_q <= rx_byte;
          else
          begin
            ptr_q <= ptr_q + 1'b1;
            if (ptr_q == `SIT_REG_CTRL)
            begin
              ctrl_wr <= 1'b1;
              ctrl_data <= rx_byte;
              // (RQ17) Self-test start code
              selftest_start <= (rx_byte == `SIT_CTRL_SELFTEST);
            end
            else if (ptr_q == `SIT_REG_FIFO)
            begin
              fifo_en <= rx_byte[`SIT_FIFO_EN_BIT];
              fifo_loopback <= rx_byte[`SIT_FIFO_LOOP_BIT];
            end
            else if (ptr_q == `SIT_REG_PASSWD)
              password_wr <= (rx_byte == `SIT_PASSWD_CODE);
            else if (ptr_q == `SIT_REG_THR_X)
              selftest_threshold[7:0] <= rx_byte;
            else if (ptr_q == `SIT_REG_THR_Y)
              selftest_threshold[15:8] <= rx_byte;
            else if (ptr_q == `SIT_REG_THR_Z)
              selftest_threshold[23:16] <= rx_byte;
            // (RQ15) Register path for rate, period, unit
            else if (ptr_q == `SIT_REG_ODR)
              odr <= rx_byte;
            else if (ptr_q == `SIT_REG_TPH)
              sync_period <= rx_byte;
            else if (ptr_q == `SIT_REG_TU)
              time_unit <= rx_byte;
          end
        end
      end
      else if (scl_fall && state_q != ST_IGN)
      begin
        // Push-pull only for I3C read data; acks stay open-drain
        if (cnt_q == `SIT_ACK_SLOT)
        begin
          sda_oe <= ack_q;
          sda_out <= 1'b0;
        end
        else if (state_q == ST_RD)
        begin
          sda_oe <= i3c_mode | ~tx_q[3'd7 - cnt_q[2:0]];
          sda_out <= i3c_mode & tx_q[3'd7 - cnt_q[2:0]];
        end
        else if (state_q == ST_ADDR && ibi_arm_q)
        begin
          sda_oe <= ~ibi_hdr[3'd7 - cnt_q[2:0]];
          sda_out <= 1'b0;
        end
        else
          sda_oe <= 1'b0;
      end
    end
  end
endmodule

// ### tb/sit_target_chk.sv
// Assertion checker on the ports of the sensor target control
`timescale 1ns/1ps
module sit_target_chk (
  input wire sys_clk,
  input wire rst,
  input wire sda_out,
  input wire sda_oe,
  input wire i3c_mode,
  input wire dyn_addr_valid,
  input wire ctrl_wr,
  input wire [7:0] ctrl_data,
  input wire selftest_start,
  input wire password_wr,
  input wire sync_tick,
  input wire ibi_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // ****************
  // Port relations
  // ****************
  sequence s_pulse(p);
    p ##1 !p;
  endsequence
  a_mode_stays_on: assert property (i3c_mode |=> i3c_mode)
    else $error("bus mode left i3c");
  a_dyn_needs_mode: assert property (dyn_addr_valid |-> i3c_mode)
    else $error("dynamic address without i3c mode");
  // Open drain in i2c, so a driven one is a fault
  a_i2c_drive_low: assert property ((sda_oe && !i3c_mode) |-> !sda_out)
    else $error("sda driven high in i2c mode");
  a_selftest_code: assert property (selftest_start |-> ctrl_data == 8'h41)
    else $error("selftest started with wrong control byte");
  a_selftest_cause: assert property (selftest_start |-> ctrl_wr || $past(ctrl_wr))
    else $error("selftest start without control write");
  a_ctrl_one_cycle: assert property (ctrl_wr |-> s_pulse(ctrl_wr))
    else $error("control write pulse too long");
  a_tick_one_cycle: assert property (sync_tick |-> s_pulse(sync_tick))
    else $error("sync tick pulse too long");
  a_pass_one_cycle: assert property (password_wr |-> s_pulse(password_wr))
    else $error("password pulse too long");
  a_ibi_needs_addr: assert property (ibi_done |-> dyn_addr_valid && i3c_mode)
    else $error("ibi finished without dynamic address");
endmodule

// ### tb/sit_host.sv
// Bus controller model: drives SCL, pulls SDA low as an open drain
`timescale 1ns/1ps
module sit_host (
  output logic scl,
  output logic sda_low,
  input wire sda
);
  // SCL stands high between frames; 16 ns phases give a 32 ns period
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic xbit(input logic b, output logic r);
    begin
      #8 sda_low = !b;
      #8 scl = 1'b1;
      #14 r = sda;
      #2 scl = 1'b0;
    end
  endtask
  task automatic start();
    begin
      #8 sda_low = 1'b0;
      #8 scl = 1'b1;
      #16 sda_low = 1'b1;
      #16 scl = 1'b0;
    end
  endtask
  task automatic stop();
    begin
      #8 sda_low = 1'b1;
      #8 scl = 1'b1;
      #16 sda_low = 1'b0;
      #16;
    end
  endtask
  // Answer to a target-driven start: take SCL low after one phase
  task automatic lead();
    begin
      #16 scl = 1'b0;
    end
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic r;
    begin
      for (int i = 7; i >= 0; i--)
        xbit(d[i], r);
      xbit(1'b1, ack_n);
    end
  endtask
  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    begin
      for (int i = 7; i >= 0; i--)
        xbit(1'b1, d[i]);
      xbit(nack, r);
    end
  endtask
endmodule

// ### tb/sit_target_bench.sv
// Testbench of the sensor target control against the controller model
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module sit_target_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ibi_pending = 1'b0;
  logic sat_sensor = 1'b1;
  logic [7:0] status_flags = 8'h5a;
  logic [7:0] secondary_status = 8'hc3;
  logic [23:0] selftest_value = 24'h64320a;
  wire scl, sda_low, sda_out, sda_oe, i3c_mode, dyn_addr_valid, ctrl_wr, selftest_start;
  wire password_wr, fifo_en, fifo_loopback, sync_tick, ibi_done;
  wire [6:0] dyn_addr;
  wire [7:0] ctrl_data, odr, sync_period, time_unit, delay_time;
  wire [23:0] selftest_threshold;
  wire [15:0] sync_ref;
  wire sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
  int n_fail = 0;
  int n_compared = 0;
  int n_st = 0;
  int n_pw = 0;
  int n_tk = 0;
  int n_ibi = 0;
  int n_cyc = 0;
  logic [7:0] b0, b1, b2;
  sit_target i_sit_target (.sys_clk, .rst, .scl, .sda_in(sda), .sda_out, .sda_oe,
    .ibi_pending, .sat_sensor, .status_flags, .secondary_status, .selftest_value,
    .i3c_mode, .dyn_addr, .dyn_addr_valid, .ctrl_wr, .ctrl_data, .selftest_start,
    .password_wr, .fifo_en, .fifo_loopback, .selftest_threshold, .odr, .sync_period,
    .time_unit, .delay_time, .sync_tick, .sync_ref, .ibi_done);
  sit_host i_sit_host (.scl, .sda_low, .sda);
  always #2 sys_clk = !sys_clk;
  always @(posedge sys_clk)
  begin
    n_st += selftest_start;
    n_pw += password_wr;
    n_tk += sync_tick;
    n_ibi += ibi_done;
    n_cyc = rst ? 0 : n_cyc + 1;
  end
  // ****************
  // Bus helpers
  // ****************
  task automatic wb(input logic [7:0] d);
    logic k;
    begin
      i_sit_host.wbyte(d, k);
      `CHK("byte ack", 1'b0, k)
    end
  endtask
  task automatic wreg(input logic [6:0] ad, input logic [7:0] r, input logic [7:0] d);
    begin
      i_sit_host.start();
      wb({ad, 1'b0});
      wb(r);
      wb(d);
      i_sit_host.stop();
    end
  endtask
  task automatic rd3(input logic [6:0] ad, input logic [7:0] r);
    begin
      i_sit_host.start();
      wb({ad, 1'b0});
      wb(r);
      i_sit_host.start();
      wb({ad, 1'b1});
      i_sit_host.rbyte(b0, 1'b0);
      i_sit_host.rbyte(b1, 1'b0);
      i_sit_host.rbyte(b2, 1'b1);
      i_sit_host.stop();
    end
  endtask
  task automatic drd(input logic [7:0] code);
    begin
      i_sit_host.start();
      wb(8'hfc);
      wb(code);
      i_sit_host.start();
      wb({7'h12, 1'b1});
      i_sit_host.rbyte(b0, 1'b0);
      i_sit_host.rbyte(b1, 1'b1);
      i_sit_host.stop();
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_selftest();
    logic k;
    logic [23:0] thr;
    begin
      i_sit_host.start();
      i_sit_host.wbyte({7'h31, 1'b0}, k);
      i_sit_host.stop();
      `CHK("foreign address nack", 1'b1, k)
      rd3(7'h30, 8'h27);
      `CHK("stored selftest values", selftest_value, {b2, b1, b0})
      for (int i = 0; i < 3; i++)
      begin
        thr[i*8 +: 8] = 8'((int'(selftest_value[i*8 +: 8]) * 4) / 5);
        wreg(7'h30, 8'h1e + 8'(i), thr[i*8 +: 8]);
      end
      rd3(7'h30, 8'h1e);
      `CHK("threshold readback", thr, {b2, b1, b0})
      `CHK("threshold port", thr, selftest_threshold)
      wreg(7'h30, 8'h1b, 8'h41);
      `CHK("selftest starts", 1, n_st)
      `CHK("control byte", 8'h41, ctrl_data)
      rd3(7'h30, 8'h18);
      `CHK("status failing", (status_flags & 8'hdf) | 8'h20, b0)
      @(posedge sys_clk) #1 sat_sensor = 1'b0;
      rd3(7'h30, 8'h18);
      `CHK("status passing", status_flags & 8'hdf, b0)
      `CHK("secondary after primary", secondary_status, b1)
    end
  endtask
  task automatic t_fifo_pass();
    begin
      wreg(7'h30, 8'h21, 8'he1);
      `CHK("password pulse", 1, n_pw)
      wreg(7'h30, 8'h0e, 8'h01);
      `CHK("fifo alone", 2'b01, {fifo_loopback, fifo_en})
      wreg(7'h30, 8'h0e, 8'h81);
      `CHK("fifo loopback", 2'b11, {fifo_loopback, fifo_en})
      // set, then reset, written back to back with no measurement between them
      wreg(7'h30, 8'h1b, 8'h08);
      `CHK("set code", 8'h08, ctrl_data)
      wreg(7'h30, 8'h1b, 8'h10);
      `CHK("reset code", 8'h10, ctrl_data)
      `CHK("no further selftest", 1, n_st)
    end
  endtask
  task automatic t_dasa();
    logic [6:0] sa [2] = '{7'h30, 7'h01};
    begin
      `CHK("starts in i2c", 1'b0, i3c_mode)
      for (int i = 0; i < 2; i++)
      begin
        i_sit_host.start();
        wb(8'hfc);
        `CHK("switch to i3c", 1'b1, i3c_mode)
        wb(8'h87);
        i_sit_host.start();
        wb({sa[i], 1'b0});
        wb({7'h11 + 7'(i), 1'b0});
        i_sit_host.stop();
        `CHK("dynamic address", {1'b1, 7'h11 + 7'(i)}, {dyn_addr_valid, dyn_addr})
      end
    end
  endtask
  task automatic t_ccc();
    begin
      drd(8'h90);
      `CHK("status first", status_flags & 8'hdf, b0)
      `CHK("status second", secondary_status, b1)
      drd(8'h95);
      `CHK("hdr caps", 8'h01, b0)
    end
  endtask
  task automatic t_xtime();
    logic [7:0] db [4] = '{8'hbf, 8'h3f, 8'h9f, 8'h8f};
    logic [15:0] t_st;
    begin
      for (int i = 0; i < 5; i++)
      begin
        if (i == 4)
          t_st = 16'(n_cyc);
        i_sit_host.start();
        wb(8'hfc);
        wb(8'h28);
        wb(i < 4 ? db[i] : 8'h7f);
        if (i < 4)
          wb(8'h21 + 8'(i));
        i_sit_host.stop();
      end
      `CHK("delay time", 8'h21, delay_time)
      `CHK("sync period", 8'h22, sync_period)
      `CHK("time unit", 8'h23, time_unit)
      `CHK("data rate", 8'h24, odr)
      `CHK("sync tick", 1, n_tk)
      wreg(7'h12, 8'h2a, 8'h5c);
      `CHK("data rate by register", 8'h5c, odr)
      // START lands 32 ns after the call, seen after the 2-flop sync
      `CHK("sync reference", 1'b1, 16'(sync_ref - t_st) inside {[16'd9:16'd11]})
      i_sit_host.start();
      wb(8'hfc);
      wb(8'h98);
      i_sit_host.start();
      wb({7'h12, 1'b0});
      wb(8'h8f);
      wb(8'h77);
      i_sit_host.stop();
      `CHK("data rate direct", 8'h77, odr)
    end
  endtask
  task automatic t_ibi();
    int w;
    begin
      @(posedge sys_clk) #1 ibi_pending = 1'b1;
      for (w = 0; w < 400 && sda; w++)
        @(posedge sys_clk) #1;
      `CHK("ibi request", 1'b0, sda)
      if (sda)
        final_report();
      i_sit_host.lead();
      i_sit_host.rbyte(b0, 1'b0);
      @(posedge sys_clk) #1 ibi_pending = 1'b0;
      i_sit_host.rbyte(b1, 1'b1);
      i_sit_host.stop();
      `CHK("ibi header", {7'h12, 1'b1}, b0)
      `CHK("mandatory byte", status_flags & 8'hdf, b1)
      `CHK("ibi done", 1, n_ibi)
    end
  endtask
  task automatic t_daa();
    logic [63:0] id;
    begin
      @(posedge sys_clk) #1 rst = 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK("mode after reset", 2'b00, {i3c_mode, dyn_addr_valid})
      i_sit_host.start();
      wb(8'hfc);
      wb(8'h07);
      i_sit_host.start();
      // header, then 64 id bits with no ack slots
      wb(8'hfd);
      for (int i = 63; i >= 0; i--)
        i_sit_host.xbit(1'b1, id[i]);
      `CHK("provisional id", {48'h0a0b0c0d0e0f, 16'h2600}, id)
      wb(8'h2a);
      i_sit_host.stop();
      `CHK("entdaa address", {1'b1, 7'h15}, {dyn_addr_valid, dyn_addr})
    end
  endtask
  task automatic final_report();
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    t_selftest();
    t_fifo_pass();
    t_dasa();
    t_ccc();
    t_xtime();
    t_ibi();
    t_daa();
    final_report();
  end
endmodule
bind sit_target sit_target_chk i_sit_target_chk (.sys_clk, .rst, .sda_out, .sda_oe,
  .i3c_mode, .dyn_addr_valid, .ctrl_wr, .ctrl_data, .selftest_start, .password_wr,
  .sync_tick, .ibi_done);
